// ===== include/mmc_regs.svh
// Address map, field positions and counts of the memory map controller.
// Assumes a 32-bit byte address from the processor core.
`ifndef MMC_REGS_SVH
`define MMC_REGS_SVH
// -----------------------------------------------------------------------
// Region boundaries
// -----------------------------------------------------------------------
`define MMC_INT_TOP      32'h0040_0000
`define MMC_PER_BASE     32'hFFC0_0000
`define MMC_MB_LSB       20
`define MMC_BANK_SPAN    32'h0010_0000
`define MMC_PSRAM_BASE   32'h0030_0000
`define MMC_XSRAM_BASE   32'h0010_0000
`define MMC_PSRAM_BYTES  32'h0000_2000
`define MMC_XSRAM_BYTES  32'h0002_0000
`define MMC_VEC_TOP      32'h0000_0020
// -----------------------------------------------------------------------
// Boot select sampling and reset values
// -----------------------------------------------------------------------
`define MMC_BOOT_SAMPLES 10
`define MMC_BOOT_XSRAM   1'b1
`define MMC_BOOT_EXT     1'b0
`define MMC_REMAP_RST    1'b0
`endif

// ===== include/mmc_pkg.sv
// Types shared by the memory map controller.
// Assumes mmc_regs.svh is on the include path.
package mmc_pkg;
  // Chip select configuration: enable, base MB, size code, waits, float.
  typedef struct packed {
    logic        en;
    logic [11:0] base;  // Address bits 31:20.
    logic [1:0]  size;  // 0: 1 MB, 1: 4 MB, 2 or 3: 16 MB.
    logic [2:0]  ws;
    logic [2:0]  tdf;
  } mmc_cs_cfg_t;
  typedef enum logic [1:0] {
    MMC_IDLE  = 2'b00,
    MMC_WAIT  = 2'b01,
    MMC_FLOAT = 2'b10
  } mmc_st_t;
  // Core access request.
  typedef struct packed {
    logic        req;
    logic        write;
    logic [1:0]  size;  // 0: byte, 1: half-word, 2: word.
    logic [31:0] addr;
  } mmc_req_t;
  // Region select outputs.
  typedef struct packed {
    logic psram;
    logic xsram;
    logic xbus;
    logic periph;
  } mmc_sel_t;
endpackage : mmc_pkg

// ===== logic/mmc_memory_map.sv
// Address decoder, remap, boot selection and abort logic for a core bus.
// Assumes one request per cycle from the core, synchronous to i_ref_clk.
// Function
// - Three regions: internal, external, peripherals.
// - Little-endian byte ordering only.
// - 8 KB primary SRAM at zero after remap.
// - Internal SRAM accesses finish in one cycle.
// - 128 KB extended SRAM at 0x0010_0000.
// - Detect writes to extended SRAM.
// - Flash reached through external bus unit.
// - First fetch at zero hits boot memory.
// - Sample boot pin last 10 reset cycles.
// - Pin high extended SRAM, low chip select zero.
// - Boot pin free as GPIO after reset.
// - Exception vectors occupy 0x0 to 0x20.
// - Writing remap one swaps boot and SRAM.
// - Remap undone only by reset.
// - Abort on undefined external address.
// - Never abort internal or peripheral accesses.
// - External unit serves 0x0040_0000 to 0xFFC0_0000.
// - Banks from eight 1 MB to eight 16 MB.
// - Aligned byte, half-word, word external accesses.
// - Per-bank wait states and float time.
// - Watchdog reset keeps boot mode.
`include "mmc_regs.svh"
module mmc_memory_map #(
  parameter int NCS = 8
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_srst,
  input  wire logic                 i_wdt_rst,
  input  wire logic                 i_boot_select_pin,
  input  wire mmc_pkg::mmc_req_t    i_req,
  input  wire mmc_pkg::mmc_cs_cfg_t i_cs_cfg [NCS],
  input  wire logic                 i_remap_wr,
  input  wire logic                 i_remap_bit,
  input  wire logic                 i_xsram_wprot,
  input  wire logic                 i_xsram_wr_clr,
  output logic                      o_busy,
  output logic                      o_done,
  output logic                      o_abort,
  output mmc_pkg::mmc_sel_t         o_sel,
  output logic [31:0]               o_local_addr,
  output logic [3:0]                o_byte_en,
  output logic [NCS-1:0]            o_chip_select_n,
  output logic                      o_remap,
  output logic                      o_boot_mode,
  output logic                      o_vector_access,
  output logic                      o_xsram_wr_flag,
  output logic                      o_gpio_line_twenty_four
);
  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    mmc_pkg::mmc_st_t  st;
    logic [2:0]        cnt;
    logic [2:0]        tdf;
    logic [9:0]        hist;
    logic              busy;
    logic              done;
    logic              abort;
    mmc_pkg::mmc_sel_t sel;
    logic [31:0]       laddr;
    logic [3:0]        be;
    logic [NCS-1:0]    cs_n;
    logic              remap;
    logic              boot;
    logic              vec;
    logic              wflag;
    logic              gpio;
  } mmc_state_t;

  mmc_state_t r;
  mmc_state_t next_r;

  // ---------------------------------------------------------------------
  // Chip select match, one comparator per bank
  // ---------------------------------------------------------------------
  logic [NCS-1:0] cs_hit;
  genvar g;
  generate
    for (g = 0; g < NCS; g++) begin : g_cs
      logic [11:0] mask;
      always_comb begin
        unique case (i_cs_cfg[g].size)
          2'd0:    mask = 12'hFFF;  // 1 MB bank.
          2'd1:    mask = 12'hFFC;  // 4 MB bank.
          default: mask = 12'hFF0;  // 16 MB bank.
        endcase
      end
      // A bank matches on its base under the size mask.
      assign cs_hit[g] = i_cs_cfg[g].en &&
        ((i_req.addr[31:20] & mask) == (i_cs_cfg[g].base & mask));
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------
  logic        in_int;
  logic        in_per;
  logic        in_low;
  logic        hit_psram;
  logic        hit_xsram;
  logic [2:0]  hit_idx;
  logic        any_hit;
  logic [31:0] aligned;

  assign in_int = i_req.addr < `MMC_INT_TOP;
  assign in_per = i_req.addr >= `MMC_PER_BASE;
  // The lowest megabyte holds the boot memory or, after remap, SRAM.
  assign in_low = i_req.addr < `MMC_BANK_SPAN;
  assign hit_psram = (in_low && r.remap &&
                      i_req.addr < `MMC_PSRAM_BYTES) ||
                     (i_req.addr >= `MMC_PSRAM_BASE &&
                      i_req.addr < `MMC_PSRAM_BASE + `MMC_PSRAM_BYTES);
  assign hit_xsram = (in_low && !r.remap &&
                      r.boot == `MMC_BOOT_XSRAM &&
                      i_req.addr < `MMC_XSRAM_BYTES) ||
                     (i_req.addr >= `MMC_XSRAM_BASE &&
                      i_req.addr < `MMC_XSRAM_BASE + `MMC_XSRAM_BYTES);
  // Drop the low address bits that the size makes meaningless.
  always_comb begin
    unique case (i_req.size)
      2'd0:    aligned = i_req.addr;
      2'd1:    aligned = {i_req.addr[31:1], 1'b0};
      default: aligned = {i_req.addr[31:2], 2'b00};
    endcase
  end
  // Lowest numbered matching bank wins when bases overlap.
  always_comb begin
    hit_idx = 3'd0;
    any_hit = 1'b0;
    for (int i = NCS - 1; i >= 0; i--) begin
      if (cs_hit[i]) begin
        hit_idx = i[2:0];
        any_hit = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    next_r.abort = 1'b0;
    next_r.hist = {r.hist[8:0], i_boot_select_pin};
    // The pin is a plain I/O line once reset is over.
    next_r.gpio = i_boot_select_pin;
    if (i_remap_wr && i_remap_bit) begin
      next_r.remap = 1'b1;
    end
    // A write of zero leaves the remap as it is.
    // Clear first, so a write flagged below in this cycle wins over it.
    if (i_xsram_wr_clr) begin
      next_r.wflag = 1'b0;
    end
    unique case (r.st)
      mmc_pkg::MMC_IDLE: begin
        next_r.sel = '0;
        if (i_req.req) begin
          next_r.done  = 1'b1;
          next_r.laddr = aligned;
          // Lane enables follow little-endian ordering only.
          unique case (i_req.size)
            2'd0:    next_r.be = 4'h1 << i_req.addr[1:0];
            2'd1:    next_r.be = i_req.addr[1] ? 4'hC : 4'h3;
            default: next_r.be = 4'hF;
          endcase
          next_r.vec = in_low && r.remap &&
                       i_req.addr < `MMC_VEC_TOP;
          if (in_int) begin
            // Internal SRAM answers next cycle, never aborts.
            next_r.sel.psram = hit_psram;
            next_r.sel.xsram = hit_xsram && !hit_psram;
            if (hit_xsram && i_req.write && i_xsram_wprot) begin
              next_r.wflag = 1'b1;
            end
            if (in_low && !r.remap && r.boot == `MMC_BOOT_EXT) begin
              // Boot from the external memory on chip select zero.
              next_r.sel  = '0;
              next_r.sel.xbus = 1'b1;
              next_r.done = 1'b0;
              next_r.busy = 1'b1;
              next_r.st   = mmc_pkg::MMC_WAIT;
              next_r.cnt  = i_cs_cfg[0].ws;
              next_r.tdf  = i_cs_cfg[0].tdf;
              next_r.cs_n[0] = 1'b0;
            end
          end else if (in_per) begin
            next_r.sel.periph = 1'b1;
          end else if (any_hit) begin
            next_r.sel.xbus = 1'b1;
            next_r.done = 1'b0;
            next_r.busy = 1'b1;
            next_r.st   = mmc_pkg::MMC_WAIT;
            next_r.cnt  = i_cs_cfg[hit_idx].ws;
            next_r.tdf  = i_cs_cfg[hit_idx].tdf;
            next_r.cs_n[hit_idx] = 1'b0;
          end else begin
            next_r.abort = 1'b1;
          end
        end
      end
      mmc_pkg::MMC_WAIT: begin
        if (r.cnt == 3'd0) begin
          next_r.done = 1'b1;
          next_r.cs_n = '1;
          next_r.sel  = '0;
          if (r.tdf == 3'd0) begin
            next_r.busy = 1'b0;
            next_r.st   = mmc_pkg::MMC_IDLE;
          end else begin
            next_r.cnt = r.tdf;
            next_r.st  = mmc_pkg::MMC_FLOAT;
          end
        end else begin
          next_r.cnt = r.cnt - 3'd1;
        end
      end
      mmc_pkg::MMC_FLOAT: begin
        // Idle cycles keep a slow device from fighting the next access.
        next_r.cnt = r.cnt - 3'd1;
        if (r.cnt == 3'd1) begin
          next_r.busy = 1'b0;
          next_r.st   = mmc_pkg::MMC_IDLE;
        end
      end
      default: begin
        next_r.st   = mmc_pkg::MMC_IDLE;
        next_r.busy = 1'b0;
      end
    endcase
    // Watchdog reset: like external reset but the boot mode stays.
    if (i_wdt_rst) begin
      next_r       = '0;
      next_r.cs_n  = '1;
      next_r.boot  = r.boot;
      next_r.hist  = r.hist;
      next_r.gpio  = i_boot_select_pin;
      next_r.remap = `MMC_REMAP_RST;
    end
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  // The reset input is already synchronised; the pin history keeps
  // shifting through reset so the last ten samples decide the boot.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      r       <= '0;
      r.cs_n  <= '1;
      r.remap <= `MMC_REMAP_RST;
      r.hist  <= next_r.hist;
      r.gpio  <= i_boot_select_pin;
      // All ten samples high selects the extended SRAM.
      r.boot  <= &next_r.hist;
    end else begin
      r <= next_r;
    end
  end

  assign o_busy          = r.busy;
  assign o_done          = r.done;
  assign o_abort         = r.abort;
  assign o_sel           = r.sel;
  assign o_local_addr    = r.laddr;
  assign o_byte_en       = r.be;
  assign o_chip_select_n = r.cs_n;
  assign o_remap         = r.remap;
  assign o_boot_mode     = r.boot;
  assign o_vector_access = r.vec;
  assign o_xsram_wr_flag = r.wflag;
  assign o_gpio_line_twenty_four = r.gpio;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  a_int_no_abort: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    !r.busy && i_req.req && (in_int || in_per) |=> !o_abort)
    else $error("abort raised for an internal access");
  a_ext_abort: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    !r.busy && i_req.req && !in_int && !in_per && !any_hit &&
    !i_wdt_rst |=> o_abort)
    else $error("undefined external address gave no abort");
  a_sram_one_cycle: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    !r.busy && i_req.req && hit_psram && !i_wdt_rst |=>
    o_done && o_sel.psram)
    else $error("primary SRAM access not done in one cycle");
  a_remap_sticky: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    o_remap && !i_wdt_rst |=> o_remap)
    else $error("remap cleared without reset");
  a_remap_zero: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    !o_remap && !(i_remap_wr && i_remap_bit) |=> !o_remap)
    else $error("remap set without a one written");
  a_remap_set: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    i_remap_wr && i_remap_bit && !i_wdt_rst |=> o_remap)
    else $error("remap write of one ignored");
  a_boot_kept: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    i_wdt_rst |=> $stable(o_boot_mode))
    else $error("watchdog reset changed boot mode");
  a_wflag_set: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    !r.busy && i_req.req && in_int && hit_xsram && i_req.write &&
    i_xsram_wprot && !i_wdt_rst |=> o_xsram_wr_flag)
    else $error("extended SRAM write not flagged");
  a_ext_wait: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    !r.busy && i_req.req && !in_int && !in_per && any_hit &&
    i_cs_cfg[hit_idx].ws == 3'd0 && !i_wdt_rst |=> o_busy ##1 o_done)
    else $error("zero wait external access not done after two cycles");
endmodule : mmc_memory_map

// ===== dv/mmc_core_model.sv
// Processor core model that issues one access at a time to the decoder.
// Assumes registered busy, done and abort outputs on the controller side.
module mmc_core_model (
  input  wire logic              i_ref_clk,
  input  wire logic              i_busy,
  input  wire logic              i_done,
  input  wire logic              i_abort,
  input  wire mmc_pkg::mmc_sel_t i_sel,
  input  wire logic [3:0]        i_byte_en,
  input  wire logic [7:0]        i_chip_select_n,
  output mmc_pkg::mmc_req_t      o_req
);
  timeunit 1ns;
  timeprecision 1ps;
  int                lat;
  logic              aborted;
  mmc_pkg::mmc_sel_t sel1;
  logic [3:0]        be1;
  logic [7:0]        cs1;
  initial o_req = '0;
  // ---------------------------------------------------------------------
  // Access task
  // ---------------------------------------------------------------------
  // Waits for idle, holds the request over the taking edge, then waits a
  // bounded time. First-cycle outputs are kept, since selects drop at done.
  task automatic access(input logic w, input logic [1:0] sz,
                        input logic [31:0] a);
    int n;
    n = 0;
    while (i_busy !== 1'b0 && n < 50) begin
      @(posedge i_ref_clk);
      #2;
      n++;
    end
    o_req = {1'b1, w, sz, a};
    @(posedge i_ref_clk);
    #2;
    o_req.req = 1'b0;
    // The cycle right after the taking edge is cycle one of the answer.
    lat = 1;
    sel1 = i_sel;
    be1 = i_byte_en;
    cs1 = i_chip_select_n;
    while (i_done !== 1'b1 && i_abort !== 1'b1 && lat < 40) begin
      @(posedge i_ref_clk);
      #2;
      lat++;
    end
    aborted = i_abort;
  endtask : access
endmodule : mmc_core_model

// ===== dv/mmc_tb.sv
// Self-checking testbench for the memory map controller.
// Assumes the core model drives requests; bench drives pins and resets.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, wdt, pin, rwr, rbit, wprot, wclr;
  logic busy, done, abort, remap, boot, vec, wflag, gpio;
  logic [31:0] laddr;
  logic [3:0] be;
  logic [7:0] cs_n;
  mmc_pkg::mmc_req_t req;
  mmc_pkg::mmc_sel_t sel;
  mmc_pkg::mmc_cs_cfg_t cfg [8];
  int err_count, n_checks;
  mmc_memory_map i_dut (.i_ref_clk(clk), .i_srst(srst), .i_wdt_rst(wdt),
    .i_boot_select_pin(pin), .i_req(req), .i_cs_cfg(cfg),
    .i_remap_wr(rwr), .i_remap_bit(rbit), .i_xsram_wprot(wprot),
    .i_xsram_wr_clr(wclr), .o_busy(busy), .o_done(done), .o_abort(abort),
    .o_sel(sel), .o_local_addr(laddr), .o_byte_en(be),
    .o_chip_select_n(cs_n), .o_remap(remap), .o_boot_mode(boot),
    .o_vector_access(vec), .o_xsram_wr_flag(wflag),
    .o_gpio_line_twenty_four(gpio));
  mmc_core_model i_core (.i_ref_clk(clk), .i_busy(busy), .i_done(done),
    .i_abort(abort), .i_sel(sel), .i_byte_en(be), .i_chip_select_n(cs_n),
    .o_req(req));
  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // Clock at 40 MHz.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  // Reset is held over 12 edges so the 10-sample boot window is full.
  task automatic do_reset(input logic p);
    @(posedge clk);
    #2;
    srst = 1'b1;
    pin = p;
    repeat (12) @(posedge clk);
    #2;
    srst = 1'b0;
  endtask : do_reset
  // One-cycle write to the remap control, checked after it lands.
  task automatic remap_wr(input logic b);
    @(posedge clk);
    #2;
    rwr = 1'b1;
    rbit = b;
    @(posedge clk);
    #2;
    rwr = 1'b0;
  endtask : remap_wr
  // Hang guard: the whole run is under a hundred cycles.
  initial begin
    #(20000 * 25);
    err_count++;
    end_sim();
  end
  // ---------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------
  initial begin
    err_count = 0;
    n_checks = 0;
    {srst, wdt, pin, rwr, rbit, wprot, wclr} = '0;
    srst = 1'b1;
    for (int i = 0; i < 8; i++) cfg[i] = '0;
    cfg[0].en = 1'b1;
    cfg[1] = '{en: 1'b1, base: 12'h004, size: 2'h0, ws: 3'h1, tdf: 3'h2};
    cfg[2] = '{en: 1'b1, base: 12'h008, size: 2'h1, ws: 3'h0, tdf: 3'h0};
    do_reset(1'b1);
    #1;
    check(boot, 1'b1);
    check(remap, 1'b0);
    check(cs_n, 8'hFF);
    i_core.access(1'b0, 2'h2, 32'h0);
    check(i_core.sel1, 4'h4);
    check(i_core.lat, 1);
    i_core.access(1'b0, 2'h0, 32'h0010_0001);
    check(i_core.sel1, 4'h4);
    check(i_core.be1, 4'h2);
    wprot = 1'b1;
    i_core.access(1'b1, 2'h1, 32'h0010_0002);
    check(i_core.be1, 4'hC);
    check(i_core.lat, 1);
    @(posedge clk);
    #1;
    check(wflag, 1'b1);
    #1;
    // A clear in the cycle of a flagged write loses to the set.
    wclr = 1'b1;
    i_core.access(1'b1, 2'h0, 32'h0010_0003);
    wclr = 1'b0;
    check(wflag, 1'b1);
    check(i_core.be1, 4'h8);
    #1;
    wclr = 1'b1;
    @(posedge clk);
    #2;
    wclr = 1'b0;
    @(posedge clk);
    #1;
    check(wflag, 1'b0);
    $display("Test boot from extended SRAM finished");
    // Remap before any chip select other than zero is used.
    remap_wr(1'b1);
    check(remap, 1'b1);
    i_core.access(1'b0, 2'h2, 32'h0000_0004);
    check(i_core.sel1, 4'h8);
    check(vec, 1'b1);
    remap_wr(1'b0);
    check(remap, 1'b1);
    i_core.access(1'b0, 2'h2, 32'hFFC0_1000);
    check({i_core.aborted, i_core.sel1}, 5'h01);
    i_core.access(1'b0, 2'h2, 32'h0020_0000);
    check({i_core.aborted, 4'(i_core.lat)}, 5'h01);
    i_core.access(1'b0, 2'h2, 32'h0040_0004);
    check({i_core.sel1, i_core.cs1}, 12'h2FD);
    check(i_core.lat, 3);
    i_core.access(1'b1, 2'h2, 32'h0040_0008);
    check({i_core.be1, 4'(i_core.lat)}, 8'hF3);
    // A 4 MB bank with no wait states answers in the second cycle.
    i_core.access(1'b0, 2'h2, 32'h0090_0010);
    check({i_core.sel1, i_core.cs1, 4'(i_core.lat)}, 16'h2FB2);
    i_core.access(1'b0, 2'h2, 32'h0800_0000);
    check(i_core.aborted, 1'b1);
    $display("Test remap and regions finished");
    @(posedge clk);
    #2;
    pin = 1'b0;
    @(posedge clk);
    #1;
    check(gpio, 1'b0);
    #1;
    pin = 1'b1;
    @(posedge clk);
    #1;
    check(gpio, 1'b1);
    #1;
    wdt = 1'b1;
    pin = 1'b0;
    @(posedge clk);
    #2;
    wdt = 1'b0;
    @(posedge clk);
    #1;
    check({boot, remap}, 2'b10);
    $display("Test watchdog reset finished");
    // Board pulls the pin low so chip select zero reaches the flash.
    do_reset(1'b0);
    #1;
    check(boot, 1'b0);
    i_core.access(1'b0, 2'h1, 32'h0000_0000);
    check({i_core.sel1, i_core.cs1}, 12'h2FE);
    check(i_core.lat, 2);
    check(laddr, 32'h0);
    $display("Test boot from external memory finished");
    end_sim();
  end
endmodule : testbench
